// ===== logic/ipx_arbiter.sv
`timescale 1ns/1ps
module ipx_arbiter (
    ipx_arb_if.arb bus // Controller side.
);
    logic       v;   // A request was found.
    logic [3:0] id;  // Winning source.
    logic       hi;  // Winner level.
    logic [3:0] src; // Source under scan.

    // Scanning the order backwards lets the earliest entry overwrite later ones;
    // the high pass runs last so any high request beats every low one.
    always_comb begin
        v = 1'b0;
        id = 4'h0;
        hi = 1'b0;
        src = 4'h0;
        for (int i = ipx_pkg::NSRC - 1; i >= 0; i--) begin
            src = ipx_pkg::ORDER[i];
            if (bus.req[src] && !bus.high[src]) begin
                v = 1'b1;
                id = src;
            end
        end
        for (int i = ipx_pkg::NSRC - 1; i >= 0; i--) begin
            src = ipx_pkg::ORDER[i];
            if (bus.req[src] && bus.high[src]) begin
                v = 1'b1;
                id = src;
                hi = 1'b1;
            end
        end
    end

    assign bus.win_valid = v;
    assign bus.win_id = id;
    assign bus.win_high = hi;
endmodule

// ===== logic/ipx_ext_detect.sv
`timescale 1ns/1ps
module ipx_ext_detect (
    input  wire logic i_mclk, // System clock.
    input  wire logic i_rst,  // Asynchronous reset, active high.
    ipx_ext_if.det    bus     // Controller side.
);
    // Synchroniser stages, previous level and the sticky edge flag.
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic flag;
    } ipx_ext_s;

    ipx_ext_s st;      // Current state.
    ipx_ext_s next_st; // Next state.
    logic     active;  // Synchronised pin is at its active polarity.

    // The pin is only tapped here, so whatever else drives or uses it is untouched.
    always_comb begin
        next_st = st;
        next_st.meta = bus.pin;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
        active = (st.sync == bus.pol);
        // A stale edge flag must not survive a switch to level mode.
        if (bus.clr || !bus.edge_sel) begin
            next_st.flag = 1'b0;
        end
        if (bus.edge_sel && active && (st.prev != bus.pol)) begin
            next_st.flag = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.pend = bus.edge_sel ? st.flag : active;
endmodule

// ===== logic/ipx_ifs.sv
`timescale 1ns/1ps
// Link between the controller and one external input detector.
interface ipx_ext_if;
    logic pin;      // Raw pin level.
    logic edge_sel; // One selects edge detection.
    logic pol;      // One selects active high.
    logic clr;      // Clears the edge flag.
    logic pend;     // Pending flag as software sees it.
    modport ctl (output pin, edge_sel, pol, clr, input pend);
    modport det (input pin, edge_sel, pol, clr, output pend);
endinterface

// Link between the controller and the priority arbiter.
interface ipx_arb_if;
    logic [ipx_pkg::NSRC-1:0] req;       // Enabled pending requests.
    logic [ipx_pkg::NSRC-1:0] high;      // High level per source.
    logic                     win_valid; // Some request wins.
    logic [3:0]               win_id;    // Winning source.
    logic                     win_high;  // Winner is high level.
    modport ctl (output req, high, input win_valid, win_id, win_high);
    modport arb (input req, high, output win_valid, win_id, win_high);
endinterface

// ===== logic/ipx_irq_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - two levels; high preempts low only
// - peripheral sources low after reset; external levels follow i_ext_prio
// - higher level wins simultaneous requests
// - requests sampled and arbitrated every cycle
// - one detect cycle plus four call
// - one instruction after return before call
// - worst case eighteen clocks via core timing
// - equal or higher service blocks new request
// - priority register bits map eight sources
// - priority register visible on two pages
// - entry pushes page and loads source page
// - stack entries readable, writable, restored
// - push on entry, pop on return
// - auto page bit gates switching, default on
// - polarity bit per external input
// - edge or level select per input
// - external inputs only observe their pins
// - pending flags at control bits 1, 3
// - edge flag cleared on vectoring
// - level flag follows active pin
module ipx_irq_ctrl (
    input  wire logic       i_mclk,      // System clock, 50 MHz.
    input  wire logic       i_rst,       // Asynchronous reset, active high.
    input  wire logic [7:0] i_src_req,   // Peripheral request flags, bit order of the priority register.
    input  wire logic [9:0] i_src_en,    // Per-source enables from the core.
    input  wire logic [1:0] i_ext_prio,  // Level of the two external inputs.
    input  wire logic [1:0] i_ext_pin,   // External interrupt pin levels, asynchronous.
    input  wire logic [7:0] i_sfr_addr,  // Register address.
    input  wire logic       i_sfr_wr,    // Register write strobe.
    input  wire logic       i_sfr_rd,    // Register read strobe.
    input  wire logic [7:0] i_sfr_wdata, // Register write data.
    input  wire logic       i_insn_end,  // Core finishes an instruction this cycle.
    input  wire logic       i_return_from_interrupt,      // Core finishes a return from interrupt.
    output logic      [7:0] o_sfr_rdata, // Read data, one cycle after the strobe.
    output logic            o_call_active, // Call into a service routine in progress.
    output logic      [3:0] o_call_src,  // Source being called.
    output logic            o_call_high, // Call is at high level.
    output logic            o_in_high,   // High-level routine in service.
    output logic            o_in_low,    // Low-level routine in service.
    output logic      [7:0] o_page_select, // Current register page.
    output logic      [1:0] o_ext_pending  // External pending flags.
);
    // Whole controller state.
    typedef struct packed {
        logic [7:0]          prio1;    // Peripheral priority bits.
        logic                auto_en;  // Automatic paging enable.
        logic [7:0]          pg_top;   // Page select, top of stack.
        logic [7:0]          pg_next;  // Second stack entry.
        logic [7:0]          pg_last;  // Third stack entry.
        logic [1:0]          edge_sel; // Edge selects.
        logic [1:0]          pol;      // Polarity selects.
        ipx_pkg::ipx_state_e fsm;      // Call sequencer.
        logic [2:0]          cnt;      // Call cycle count.
        logic                det_valid; // Request detected last cycle.
        logic [3:0]          det_id;   // Detected source.
        logic                det_high; // Detected level.
        logic [3:0]          call_id;  // Source under call.
        logic                call_high; // Level under call.
        logic                in_high;  // High routine in service.
        logic                in_low;   // Low routine in service.
        logic [7:0]          rdata;    // Read data register.
    } ipx_main_s;

    ipx_main_s  st;        // Current state.
    ipx_main_s  next_st;   // Next state.
    ipx_ext_if  ext_bus [2] (); // One link per external input.
    ipx_arb_if  arb_bus ();    // Arbiter link.
    logic [1:0] ext_pend;  // Pending flags from detectors.
    logic       entry;     // Last call cycle: routine entered.
    logic       start;     // Call starts this cycle.
    logic       eligible;  // Detected request may be serviced.
    logic       wr_timer_control_reg;   // Software write to the control register.
    logic       p0;        // Page 0 selected.
    logic       pf;        // Page 0x0F selected.
    logic [7:0] rd_mux;    // Read value.

    for (genvar g = 0; g < 2; g++) begin : g_ext
        assign ext_bus[g].pin = i_ext_pin[g];
        assign ext_bus[g].edge_sel = st.edge_sel[g];
        assign ext_bus[g].pol = st.pol[g];
        assign ext_bus[g].clr = (entry && st.call_id == 4'(32'(ipx_pkg::SRC_EXT0) + g))
                                || (wr_timer_control_reg && !i_sfr_wdata[2 * g + 1]);
        assign ext_pend[g] = ext_bus[g].pend;
        ipx_ext_detect u_det (
            .i_mclk (i_mclk),
            .i_rst  (i_rst),
            .bus    (ext_bus[g])
        );
    end

    assign arb_bus.req = i_src_en & {ext_pend, i_src_req};
    assign arb_bus.high = {i_ext_prio, st.prio1};

    ipx_arbiter u_arb (
        .bus (arb_bus)
    );

    assign p0 = (st.pg_top == ipx_pkg::PAGE_0);
    assign pf = (st.pg_top == ipx_pkg::PAGE_F);
    assign wr_timer_control_reg = i_sfr_wr && p0 && (i_sfr_addr == ipx_pkg::ADDR_TIMER_CONTROL_REG);
    assign entry = (st.fsm == ipx_pkg::ST_CALL) && (st.cnt == ipx_pkg::CALL_LAST);

    assign eligible = st.det_valid && !st.in_high && (st.det_high || !st.in_low);
    assign start = (st.fsm == ipx_pkg::ST_IDLE) && eligible && i_insn_end && !i_return_from_interrupt;

    // Read multiplexer; registers absent from the current page read as zero.
    always_comb begin
        rd_mux = 8'h00;
        case (i_sfr_addr)
            ipx_pkg::ADDR_PRIO1: rd_mux = (p0 || pf) ? st.prio1 : 8'h00;
            ipx_pkg::ADDR_TIMER_CONTROL_REG: begin
                if (p0) begin
                    rd_mux[ipx_pkg::TIMER_CONTROL_REG_EDGE0] = st.edge_sel[0];
                    rd_mux[ipx_pkg::TIMER_CONTROL_REG_PEND0] = ext_pend[0];
                    rd_mux[ipx_pkg::TIMER_CONTROL_REG_EDGE1] = st.edge_sel[1];
                    rd_mux[ipx_pkg::TIMER_CONTROL_REG_PEND1] = ext_pend[1];
                end
            end
            ipx_pkg::ADDR_XCFG: rd_mux = p0 ? {6'h00, st.pol} : 8'h00;
            ipx_pkg::ADDR_PCTL: rd_mux = {7'h00, st.auto_en};
            ipx_pkg::ADDR_PSEL: rd_mux = st.pg_top;
            ipx_pkg::ADDR_PNEXT: rd_mux = st.pg_next;
            ipx_pkg::ADDR_PLAST: rd_mux = st.pg_last;
            default: rd_mux = 8'h00;
        endcase
    end

    // Next-state logic: software writes first, hardware stack moves after, so a
    // push or pop in the same cycle as a write takes precedence.
    always_comb begin
        next_st = st;
        if (i_sfr_rd) begin
            next_st.rdata = rd_mux;
        end
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                ipx_pkg::ADDR_PRIO1: begin
                    if (p0 || pf) begin
                        next_st.prio1 = i_sfr_wdata;
                    end
                end
                ipx_pkg::ADDR_TIMER_CONTROL_REG: begin
                    if (p0) begin
                        next_st.edge_sel[0] = i_sfr_wdata[ipx_pkg::TIMER_CONTROL_REG_EDGE0];
                        next_st.edge_sel[1] = i_sfr_wdata[ipx_pkg::TIMER_CONTROL_REG_EDGE1];
                    end
                end
                ipx_pkg::ADDR_XCFG: begin
                    if (p0) begin
                        next_st.pol[0] = i_sfr_wdata[ipx_pkg::XCFG_POL0];
                        next_st.pol[1] = i_sfr_wdata[ipx_pkg::XCFG_POL1];
                    end
                end
                ipx_pkg::ADDR_PCTL: next_st.auto_en = i_sfr_wdata[ipx_pkg::PCTL_AUTO];
                ipx_pkg::ADDR_PSEL: next_st.pg_top = i_sfr_wdata;
                ipx_pkg::ADDR_PNEXT: next_st.pg_next = i_sfr_wdata;
                ipx_pkg::ADDR_PLAST: next_st.pg_last = i_sfr_wdata;
                default: begin
                end
            endcase
        end

        next_st.det_valid = arb_bus.win_valid;
        next_st.det_id = arb_bus.win_id;
        next_st.det_high = arb_bus.win_high;

        case (st.fsm)
            ipx_pkg::ST_IDLE: begin
                if (start) begin
                    next_st.fsm = ipx_pkg::ST_CALL;
                    next_st.cnt = 3'h0;
                    next_st.call_id = st.det_id;
                    next_st.call_high = st.det_high;
                end
            end
            ipx_pkg::ST_CALL: begin
                next_st.cnt = st.cnt + 3'h1;
                if (entry) begin
                    next_st.fsm = ipx_pkg::ST_IDLE;
                    next_st.cnt = 3'h0;
                end
            end
            default: next_st.fsm = ipx_pkg::ST_IDLE;
        endcase

        // Entry marks the level in service and, when enabled, pushes the page.
        if (entry) begin
            if (st.call_high) begin
                next_st.in_high = 1'b1;
            end else begin
                next_st.in_low = 1'b1;
            end
            if (st.auto_en) begin
                next_st.pg_last = st.pg_next;
                next_st.pg_next = st.pg_top;
                next_st.pg_top = ipx_pkg::SRC_PAGE[st.call_id];
            end
        end else if (i_return_from_interrupt) begin
            // The innermost active level ends first.
            if (st.in_high) begin
                next_st.in_high = 1'b0;
            end else begin
                next_st.in_low = 1'b0;
            end
            if (st.auto_en) begin
                next_st.pg_top = st.pg_next;
                next_st.pg_next = st.pg_last;
            end
        end
    end

    // State register.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.prio1 <= ipx_pkg::PRIO1_RST;
            st.auto_en <= ipx_pkg::AUTO_RST;
            st.pg_top <= ipx_pkg::PAGE_RST;
            st.pg_next <= ipx_pkg::PAGE_RST;
            st.pg_last <= ipx_pkg::PAGE_RST;
            st.pol <= ipx_pkg::XCFG_RST;
            st.edge_sel <= ipx_pkg::EDGE_RST;
            st.fsm <= ipx_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign o_sfr_rdata = st.rdata;
    assign o_call_active = (st.fsm == ipx_pkg::ST_CALL);
    assign o_call_src = st.call_id;
    assign o_call_high = st.call_high;
    assign o_in_high = st.in_high;
    assign o_in_low = st.in_low;
    assign o_page_select = st.pg_top;
    assign o_ext_pending = ext_pend;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_detect;
        st.det_valid && start;
    endsequence
    sequence s_call;
        o_call_active [*4] ##1 !o_call_active;
    endsequence

    property p_call_len;
        s_detect |=> s_call;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call not four cycles");

    property p_detect_first;
        $rose(o_call_active) |-> $past(st.det_valid) && $past(st.det_id) == o_call_src;
    endproperty
    a_detect_first: assert property (p_detect_first) else $error("call without detection");

    property p_high_never_preempted;
        $rose(o_call_active) |-> !$past(o_in_high);
    endproperty
    a_high_never_preempted: assert property (p_high_never_preempted) else $error("high preempted");

    property p_equal_waits;
        $rose(o_call_active) && !o_call_high |-> !$past(o_in_low);
    endproperty
    a_equal_waits: assert property (p_equal_waits) else $error("equal level preempted");

    property p_return_from_interrupt_gap;
        i_return_from_interrupt |=> !$rose(o_call_active);
    endproperty
    a_return_from_interrupt_gap: assert property (p_return_from_interrupt_gap) else $error("call on return boundary");

    property p_push;
        entry && st.auto_en |=> o_page_select == ipx_pkg::SRC_PAGE[$past(st.call_id)]
                                && st.pg_next == $past(st.pg_top) && st.pg_last == $past(st.pg_next);
    endproperty
    a_push: assert property (p_push) else $error("page push wrong");

    property p_pop;
        i_return_from_interrupt && !entry && st.auto_en |=> o_page_select == $past(st.pg_next);
    endproperty
    a_pop: assert property (p_pop) else $error("page pop wrong");

    property p_no_auto;
        (entry || i_return_from_interrupt) && !st.auto_en && !i_sfr_wr |=> $stable(o_page_select) && $stable(st.pg_next);
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("stack moved while disabled");

    property p_prio_page_f;
        i_sfr_rd && i_sfr_addr == ipx_pkg::ADDR_PRIO1 && pf |=> o_sfr_rdata == $past(st.prio1);
    endproperty
    a_prio_page_f: assert property (p_prio_page_f) else $error("priority unreadable on page 0x0f");
endmodule

// ===== logic/ipx_pkg.sv
package ipx_pkg;
    // Number of request sources: eight peripheral lines plus two external inputs.
    localparam int NSRC = 10;
    // Source indices of the two external inputs; 0 to 7 follow the priority register bits.
    localparam logic [3:0] SRC_EXT0 = 4'h8;
    localparam logic [3:0] SRC_EXT1 = 4'h9;

    // Register addresses on the special-register bus.
    localparam logic [7:0] ADDR_PRIO1 = 8'hf6;
    localparam logic [7:0] ADDR_TIMER_CONTROL_REG  = 8'ha0;
    localparam logic [7:0] ADDR_XCFG  = 8'ha1;
    localparam logic [7:0] ADDR_PCTL  = 8'ha2;
    localparam logic [7:0] ADDR_PSEL  = 8'ha3;
    localparam logic [7:0] ADDR_PNEXT = 8'ha4;
    localparam logic [7:0] ADDR_PLAST = 8'ha5;

    // Pages on which the priority register is visible.
    localparam logic [7:0] PAGE_0 = 8'h00;
    localparam logic [7:0] PAGE_F = 8'h0f;

    // Field positions.
    localparam int TIMER_CONTROL_REG_EDGE0 = 0;
    localparam int TIMER_CONTROL_REG_PEND0 = 1;
    localparam int TIMER_CONTROL_REG_EDGE1 = 2;
    localparam int TIMER_CONTROL_REG_PEND1 = 3;
    localparam int XCFG_POL0  = 0;
    localparam int XCFG_POL1  = 1;
    localparam int PCTL_AUTO  = 0;

    // Reset values.
    localparam logic [7:0] PRIO1_RST = 8'h00;
    localparam logic       AUTO_RST  = 1'b1;
    localparam logic [7:0] PAGE_RST  = 8'h00;
    localparam logic [1:0] XCFG_RST  = 2'h0;
    localparam logic [1:0] EDGE_RST  = 2'h0;

    // Call into the service routine lasts this many system clocks.
    localparam int         CALL_CYC  = 4;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYC - 1);

    // Same-level tie order: the first entry wins.
    localparam logic [3:0] ORDER [NSRC] = '{4'h8, 4'h0, 4'h9, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    // Page loaded on entry for each source.
    localparam logic [7:0] SRC_PAGE [NSRC] = '{default: 8'h00};

    // Call sequencer states.
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_CALL = 1'b1} ipx_state_e;
endpackage

// ===== verification/ipx_core_model.sv
`timescale 1ns/1ps
// Behavioural core and external request sources facing the controller.
module ipx_core_model (
    input  wire logic       i_mclk,     // System clock.
    input  wire logic       i_rst,      // Asynchronous reset, active high.
    input  wire logic       i_stall,    // Holds the running instruction open.
    input  wire logic       i_ret_go,   // Finishes a return in the next cycle.
    input  wire logic [1:0] i_ext_req,  // Asks each source to activate its pin.
    input  wire logic [1:0] i_ext_pol,  // Active level each source uses.
    input  wire logic       i_served,   // A service routine has been entered.
    output logic            o_insn_end, // Instruction completes this cycle.
    output logic            o_return_from_interrupt,     // Return completes this cycle.
    output logic      [1:0] o_ext_pin   // External pin levels.
);
    typedef struct packed {logic insn; logic ret; logic [1:0] pin;} ipx_core_s;
    ipx_core_s st;      // Registered state.
    ipx_core_s next_st; // Next state.
    // Short instructions end every cycle, so a stall stands in for a long one.
    always_comb begin
        next_st.insn = !i_stall;
        next_st.ret  = i_ret_go;
        next_st.pin  = i_ext_pol ~^ (i_ext_req & {2{!i_served}});
    end
    // Pins start inactive so no request is seen straight out of reset.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st <= '{insn: 1'b0, ret: 1'b0, pin: ~i_ext_pol};
        end else begin
            st <= next_st;
        end
    end
    assign o_insn_end = st.insn;
    assign o_return_from_interrupt     = st.ret;
    assign o_ext_pin  = st.pin;
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
// Self-checking bench: drives registers, requests and returns, judges the ports.
module tb;
    logic       mclk, rst, wr_s, rd_s, stall, ret_go;   // Clock, reset and strobes.
    logic [7:0] src_req, addr, wdata;                   // Requests and register bus.
    logic [9:0] src_en;                                 // Source enables.
    logic [1:0] ext_prio, ext_req, ext_pol, pin, pend;  // External input side.
    logic       insn_end, return_from_interrupt, call, c_high, in_h, in_l; // Core and call state.
    logic [7:0] rdata, page;                            // Read data and page.
    logic [3:0] src;                                    // Called source.
    int         fails, samples_checked;                 // Mismatch and check counts.
    ipx_irq_ctrl ipx_irq_ctrl_i (.i_mclk(mclk), .i_rst(rst), .i_src_req(src_req), .i_src_en(src_en),
        .i_ext_prio(ext_prio), .i_ext_pin(pin), .i_sfr_addr(addr), .i_sfr_wr(wr_s), .i_sfr_rd(rd_s),
        .i_sfr_wdata(wdata), .i_insn_end(insn_end), .i_return_from_interrupt(return_from_interrupt), .o_sfr_rdata(rdata),
        .o_call_active(call), .o_call_src(src), .o_call_high(c_high), .o_in_high(in_h),
        .o_in_low(in_l), .o_page_select(page), .o_ext_pending(pend));
    ipx_core_model ipx_core_model_i (.i_mclk(mclk), .i_rst(rst), .i_stall(stall), .i_ret_go(ret_go),
        .i_ext_req(ext_req), .i_ext_pol(ext_pol), .i_served(in_h | in_l), .o_insn_end(insn_end),
        .o_return_from_interrupt(return_from_interrupt), .o_ext_pin(pin));
    // Free-running clock, 20 ns period.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Settle one nanosecond after the edge so registered outputs have landed.
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask
    // Bounded wait for a call; running out ends the run as a failure.
    task automatic wait_call(input int lim);
        int k;
        k = 0;
        while (call !== 1'b1 && k < lim) begin
            step(1);
            k++;
        end
        if (k == lim) begin
            chk("call start", 8'h00, 8'h01);
            tally_and_finish();
        end
    endtask
    // Drops every request and lets the core return from the routine.
    task automatic leave();
        @(posedge mclk);
        src_req <= 8'h00;
        ext_req <= 2'b00;
        ret_go <= 1'b1;
        @(posedge mclk);
        ret_go <= 1'b0;
        step(2);
    endtask
    task automatic t_regs();
        rd("prio reset", ipx_pkg::ADDR_PRIO1, 8'h00);
        rd("auto reset", ipx_pkg::ADDR_PCTL, 8'h01);
        wr(ipx_pkg::ADDR_PRIO1, 8'ha5);
        rd("prio page 0", ipx_pkg::ADDR_PRIO1, 8'ha5);
        wr(ipx_pkg::ADDR_PSEL, ipx_pkg::PAGE_F);
        rd("prio page f", ipx_pkg::ADDR_PRIO1, 8'ha5);
        wr(ipx_pkg::ADDR_PSEL, 8'h01);
        wr(ipx_pkg::ADDR_PRIO1, 8'hff);
        rd("prio off page", ipx_pkg::ADDR_PRIO1, 8'h00);
        rd("unmapped", 8'h00, 8'h00);
        wr(ipx_pkg::ADDR_PSEL, ipx_pkg::PAGE_0);
        rd("prio kept", ipx_pkg::ADDR_PRIO1, 8'ha5);
        wr(ipx_pkg::ADDR_PRIO1, 8'h00);
        $display("registers done");
    endtask
    task automatic t_latency();
        wr(ipx_pkg::ADDR_PSEL, 8'h05);
        @(posedge mclk);
        src_req <= 8'h01;
        step(1);
        chk("call at detect", 8'(call), 8'h00);
        step(1);
        chk("call first", 8'(call), 8'h01);
        step(3);
        chk("call fourth", 8'(call), 8'h01);
        step(1);
        chk("call over", 8'(call), 8'h00);
        chk("in low", 8'(in_l), 8'h01);
        chk("entry page", page, 8'h00);
        rd("pushed page", ipx_pkg::ADDR_PNEXT, 8'h05);
        wr(ipx_pkg::ADDR_PNEXT, 8'h07);
        step(1);
        chk("no early pop", page, 8'h00);
        leave();
        chk("restored page", page, 8'h07);
        wr(ipx_pkg::ADDR_PSEL, ipx_pkg::PAGE_0);
        $display("latency done");
    endtask
    task automatic t_preempt();
        wr(ipx_pkg::ADDR_PRIO1, 8'h90);
        @(posedge mclk);
        src_req <= 8'h01;
        wait_call(8);
        step(4);
        @(posedge mclk);
        src_req <= 8'h81;
        wait_call(8);
        chk("preempt level", 8'(c_high), 8'h01);
        step(4);
        chk("in high", 8'(in_h), 8'h01);
        @(posedge mclk);
        src_req <= 8'h11;
        step(10);
        chk("high not preempted", 8'(call), 8'h00);
        @(posedge mclk);
        ret_go <= 1'b1;
        stall <= 1'b1;
        @(posedge mclk);
        ret_go <= 1'b0;
        repeat (8) begin
            step(1);
            chk("wait after return", 8'(call), 8'h00);
        end
        @(posedge mclk);
        stall <= 1'b0;
        wait_call(6);
        chk("pending source", {4'h0, src}, 8'h04);
        step(4);
        leave();
        leave();
        chk("all left", {6'h00, in_h, in_l}, 8'h00);
        $display("preemption done");
    endtask
    task automatic t_ties();
        wr(ipx_pkg::ADDR_PRIO1, 8'h00);
        @(posedge mclk);
        src_req <= 8'h03;
        wait_call(8);
        chk("tie winner", {4'h0, src}, 8'h00);
        step(4);
        leave();
        wr(ipx_pkg::ADDR_PRIO1, 8'h80);
        @(posedge mclk);
        src_req <= 8'h81;
        wait_call(8);
        chk("level winner", {4'h0, src}, 8'h07);
        step(4);
        leave();
        wr(ipx_pkg::ADDR_PRIO1, 8'h00);
        $display("ties done");
    endtask
    task automatic t_ext();
        step(4);
        chk("inactive low pol", {6'h00, pend}, 8'h00);
        @(posedge mclk);
        ext_req <= 2'b01;
        step(4);
        chk("active low pol", {6'h00, pend}, 8'h01);
        rd("flag bit 1", ipx_pkg::ADDR_TIMER_CONTROL_REG, 8'h02);
        wr(ipx_pkg::ADDR_XCFG, 8'h03);
        ext_pol <= 2'b11;
        ext_req <= 2'b10;
        step(4);
        rd("flag bit 3", ipx_pkg::ADDR_TIMER_CONTROL_REG, 8'h08);
        @(posedge mclk);
        ext_req <= 2'b00;
        step(4);
        chk("level follows pin", {6'h00, pend}, 8'h00);
        wr(ipx_pkg::ADDR_TIMER_CONTROL_REG, 8'h05);
        src_en <= 10'h1ff;
        ext_req <= 2'b01;
        wait_call(10);
        chk("edge source", {4'h0, src}, 8'h08);
        step(4);
        chk("edge flag cleared", {6'h00, pend}, 8'h00);
        leave();
        $display("external done");
    endtask
    task automatic t_auto_off();
        wr(ipx_pkg::ADDR_PCTL, 8'h00);
        wr(ipx_pkg::ADDR_PSEL, 8'h03);
        src_req <= 8'h01;
        wait_call(8);
        step(4);
        chk("no switch", page, 8'h03);
        leave();
        chk("no pop", page, 8'h03);
        $display("auto page off done");
    endtask
    // Main sequence: reset held 12 cycles, then each scenario in turn.
    initial begin
        {rst, wr_s, rd_s, stall, ret_go} = 5'h10;
        {src_req, addr, wdata} = 24'h000000;
        {src_en, ext_prio, ext_req, ext_pol} = {10'h0ff, 6'h00};
        fails = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_latency();
        t_preempt();
        t_ties();
        t_ext();
        t_auto_off();
        tally_and_finish();
    end
endmodule
